/* File: dcw_decoder.sv */
// Control word decoder with Wishbone register slave
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
module dcw_decoder (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] evt_cond_i,
   input wire logic speed_zero_i,
   output logic run_o,
   output logic coast_o,
   output logic quick_stop_o,
   output logic ramp_down_o,
   output logic ramp_function_generator_reset_o,
   output logic [15:0] speed_ref_o,
   output logic bus_input_1_select_o,
   output logic bus_input_2_select_o,
   output logic bus_input_3_select_o,
   output logic bus_input_4_select_o,
   output logic lockout_o,
   output logic [3:0] events_o,
   output logic irq_o
);
   logic rst_meta_r;
   logic rst_n;
   logic [15:0] ctw_r;
   logic [15:0] speed_set_r;
   logic place_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic [3:0] evt_r;
   logic ref_valid_r;
   logic [15:0] ref_acc_r;
   logic [15:0] ref_nxt;
   dcw_pkg::dcw_state_e state_r;
   dcw_pkg::dcw_state_e state_nxt;
   logic [1:0] rise_w;
   logic wr_en;
   logic rd_en;
   logic cmd_en;
   logic fault;
   logic b_on;
   logic b_coast;
   logic b_qs;
   logic b_op;
   logic mod_nxt;
   logic [2:0] irq_set;

   // Reset release through two flops
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign cmd_en = place_r;
   assign fault = |evt_r;
   assign b_on = ctw_r[dcw_pkg::B_ON];
   assign b_coast = ctw_r[dcw_pkg::B_COAST];
   assign b_qs = ctw_r[dcw_pkg::B_QSTOP];
   assign b_op = ctw_r[dcw_pkg::B_OPER];

   dcw_edge #(.N(2)) u_edge (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .d_i({ctw_r[dcw_pkg::B_EVRST], b_op}),
      .rise_o(rise_w)
   );

   // Wishbone register writes; bits 8, 9 and 11 stored but never decoded
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctw_r <= dcw_pkg::CTW_RST;
         speed_set_r <= dcw_pkg::SPEED_RST;
         place_r <= dcw_pkg::CFG_PLACE_RST;
         irq_mask_r <= dcw_pkg::MASK_RST;
      end else if (wr_en) begin
         case (wb_adr_i)
            dcw_pkg::OFS_CTW: begin
               if (wb_sel_i[0]) ctw_r[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) ctw_r[15:8] <= wb_dat_i[15:8];
            end
            dcw_pkg::OFS_SPEED: begin
               if (wb_sel_i[0]) speed_set_r[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) speed_set_r[15:8] <= wb_dat_i[15:8];
            end
            dcw_pkg::OFS_CFG: begin
               if (wb_sel_i[0]) place_r <= wb_dat_i[0];
            end
            dcw_pkg::OFS_IRQ_MASK: begin
               if (wb_sel_i[0]) irq_mask_r <= wb_dat_i[2:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data and single-cycle ack
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (rd_en) begin
            case (wb_adr_i)
               dcw_pkg::OFS_CTW: wb_dat_o <= {16'h0000, ctw_r};
               dcw_pkg::OFS_SPEED: wb_dat_o <= {16'h0000, speed_set_r};
               dcw_pkg::OFS_CFG: wb_dat_o <= {31'h0000_0000, place_r};
               dcw_pkg::OFS_STATE: wb_dat_o <= {24'h00_0000, evt_r, ref_valid_r, state_r};
               dcw_pkg::OFS_IRQ_STAT: wb_dat_o <= {29'h0000_0000, irq_stat_r};
               dcw_pkg::OFS_IRQ_MASK: wb_dat_o <= {29'h0000_0000, irq_mask_r};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Event flags; a live condition always wins over the reset edge
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         evt_r <= 4'h0;
      end else if (cmd_en && rise_w[1]) begin
         evt_r <= evt_cond_i;
      end else begin
         evt_r <= evt_r | evt_cond_i;
      end
   end

   // Drive state sequencer
   always_comb begin
      state_nxt = state_r;
      if (fault && state_r != dcw_pkg::S_LOCK) begin
         state_nxt = dcw_pkg::S_LOCK;
      end else if (cmd_en) begin
         case (state_r)
            dcw_pkg::S_LOCK: begin
               if (!b_on && b_coast && b_qs && !fault) state_nxt = dcw_pkg::S_READY;
            end
            dcw_pkg::S_READY: begin
               if (!b_coast || !b_qs) state_nxt = dcw_pkg::S_LOCK;
               else if (b_on) state_nxt = dcw_pkg::S_ON;
            end
            dcw_pkg::S_ON: begin
               if (!b_coast || !b_qs) state_nxt = dcw_pkg::S_LOCK;
               else if (!b_on) state_nxt = dcw_pkg::S_READY;
               else if (rise_w[0]) state_nxt = dcw_pkg::S_RUN;
            end
            dcw_pkg::S_RUN: begin
               if (!b_coast) state_nxt = dcw_pkg::S_LOCK;
               else if (!b_qs) state_nxt = dcw_pkg::S_QSTOP;
               else if (!b_on) state_nxt = dcw_pkg::S_RAMP;
               else if (!b_op) state_nxt = dcw_pkg::S_ON;
            end
            dcw_pkg::S_RAMP: begin
               if (!b_coast) state_nxt = dcw_pkg::S_LOCK;
               else if (speed_zero_i) state_nxt = dcw_pkg::S_READY;
            end
            dcw_pkg::S_QSTOP: begin
               if (!b_coast || speed_zero_i) state_nxt = dcw_pkg::S_LOCK;
            end
            default: state_nxt = dcw_pkg::S_LOCK;
         endcase
      end
   end

   assign mod_nxt = (state_nxt == dcw_pkg::S_RUN) || (state_nxt == dcw_pkg::S_RAMP) ||
                    (state_nxt == dcw_pkg::S_QSTOP);

   // Power-up lands in lockout so a stale word cannot start the motor
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= dcw_pkg::S_LOCK;
         run_o <= 1'b0;
         quick_stop_o <= 1'b0;
         ramp_down_o <= 1'b0;
         lockout_o <= 1'b1;
         coast_o <= 1'b1;
      end else begin
         state_r <= state_nxt;
         run_o <= mod_nxt;
         quick_stop_o <= state_nxt == dcw_pkg::S_QSTOP;
         ramp_down_o <= state_nxt == dcw_pkg::S_RAMP;
         lockout_o <= state_nxt == dcw_pkg::S_LOCK;
         coast_o <= !mod_nxt;
      end
   end

   // Process data acceptance and reference path
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ref_acc_r <= 16'h0000;
         ref_valid_r <= 1'b0;
      end else if (cmd_en && ctw_r[dcw_pkg::B_FBCTL]) begin
         ref_acc_r <= speed_set_r;
         ref_valid_r <= 1'b1;
      end
   end

   always_comb begin
      ref_nxt = speed_ref_o;
      if (!cmd_en) begin
         ref_nxt = speed_ref_o;
      end else if (!ctw_r[dcw_pkg::B_REFEN]) begin
         ref_nxt = 16'h0000;
      end else if (ctw_r[dcw_pkg::B_UNFRZ]) begin
         ref_nxt = ref_valid_r ? ref_acc_r : 16'h0000;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         speed_ref_o <= 16'h0000;
         ramp_function_generator_reset_o <= 1'b1;
      end else begin
         speed_ref_o <= ref_nxt;
         if (cmd_en) ramp_function_generator_reset_o <= !ctw_r[dcw_pkg::B_RAMP];
      end
   end

   // Fieldbus inputs pass whatever the control place
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         bus_input_1_select_o <= 1'b0;
         bus_input_2_select_o <= 1'b0;
         bus_input_3_select_o <= 1'b0;
         bus_input_4_select_o <= 1'b0;
         events_o <= 4'h0;
      end else begin
         bus_input_1_select_o <= ctw_r[dcw_pkg::B_IN_LO];
         bus_input_2_select_o <= ctw_r[dcw_pkg::B_IN_LO + 1];
         bus_input_3_select_o <= ctw_r[dcw_pkg::B_IN_LO + 2];
         bus_input_4_select_o <= ctw_r[dcw_pkg::B_IN_LO + 3];
         events_o <= evt_r;
      end
   end

   // Interrupts: set beats write-one-to-clear
   assign irq_set[dcw_pkg::IRQ_EVT] = |(evt_cond_i & ~evt_r);
   assign irq_set[dcw_pkg::IRQ_LOCK] = (state_nxt == dcw_pkg::S_LOCK) && (state_r != dcw_pkg::S_LOCK);
   assign irq_set[dcw_pkg::IRQ_RUN] = (state_nxt == dcw_pkg::S_RUN) && (state_r == dcw_pkg::S_ON);

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= 3'h0;
         irq_o <= 1'b0;
      end else begin
         if (wr_en && wb_adr_i == dcw_pkg::OFS_IRQ_STAT && wb_sel_i[0]) begin
            irq_stat_r <= (irq_stat_r & ~wb_dat_i[2:0]) | irq_set;
         end else begin
            irq_stat_r <= irq_stat_r | irq_set;
         end
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   property p_start_edge;
      @(posedge mclk_i) disable iff (!rst_n)
      $rose(run_o) |-> $past(b_op) && !$past(b_op, 2) && $past(cmd_en);
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("run began without bit 3 edge");

   property p_coast;
      @(posedge mclk_i) disable iff (!rst_n)
      (cmd_en && !b_coast && !fault) |=> lockout_o && !run_o;
   endproperty
   a_coast: assert property (p_coast) else $error("coast request did not stop drive");

   property p_op_low;
      @(posedge mclk_i) disable iff (!rst_n)
      (state_r == dcw_pkg::S_RUN && cmd_en && b_qs && b_on && !b_op) |=> !run_o;
   endproperty
   a_op_low: assert property (p_op_low) else $error("bit 3 low left drive running");

   property p_qstop;
      @(posedge mclk_i) disable iff (!rst_n)
      (state_r == dcw_pkg::S_RUN && cmd_en && b_coast && !b_qs && !fault) |=> quick_stop_o && run_o;
   endproperty
   a_qstop: assert property (p_qstop) else $error("quick stop not entered");

   property p_ramp_off;
      @(posedge mclk_i) disable iff (!rst_n)
      (state_r == dcw_pkg::S_RUN && cmd_en && b_coast && b_qs && !b_on && !fault) |=> ramp_down_o;
   endproperty
   a_ramp_off: assert property (p_ramp_off) else $error("off did not ramp down");

   property p_fault_lock;
      @(posedge mclk_i) disable iff (!rst_n)
      fault |=> lockout_o;
   endproperty
   a_fault_lock: assert property (p_fault_lock) else $error("fault did not lock out");

   property p_lock_hold;
      @(posedge mclk_i) disable iff (!rst_n)
      (state_r == dcw_pkg::S_LOCK && b_on) |=> lockout_o;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lockout left with bit 0 high");

   property p_ref_zero;
      @(posedge mclk_i) disable iff (!rst_n)
      (cmd_en && !ctw_r[dcw_pkg::B_REFEN]) |=> speed_ref_o == 16'h0000;
   endproperty
   a_ref_zero: assert property (p_ref_zero) else $error("reference not forced to zero");

   property p_freeze;
      @(posedge mclk_i) disable iff (!rst_n)
      (cmd_en && ctw_r[dcw_pkg::B_REFEN] && !ctw_r[dcw_pkg::B_UNFRZ]) |=> $stable(speed_ref_o);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen reference changed");

   property p_no_place;
      @(posedge mclk_i) disable iff (!rst_n)
      (!cmd_en && !fault) |=> $stable(state_r) && $stable(speed_ref_o);
   endproperty
   a_no_place: assert property (p_no_place) else $error("command acted without control place");

   property p_evt_keep;
      @(posedge mclk_i) disable iff (!rst_n)
      evt_cond_i[0] |=> evt_r[0];
   endproperty
   a_evt_keep: assert property (p_evt_keep) else $error("live event was cleared");

   property p_accept;
      @(posedge mclk_i) disable iff (!rst_n)
      (cmd_en && ctw_r[dcw_pkg::B_FBCTL]) |=> ref_acc_r == $past(speed_set_r);
   endproperty
   a_accept: assert property (p_accept) else $error("process data not accepted");

   property p_ignore;
      @(posedge mclk_i) disable iff (!rst_n)
      !ctw_r[dcw_pkg::B_FBCTL] |=> $stable(ref_acc_r);
   endproperty
   a_ignore: assert property (p_ignore) else $error("process data taken while ignored");

   property p_rfg;
      @(posedge mclk_i) disable iff (!rst_n)
      cmd_en |=> ramp_function_generator_reset_o == !$past(ctw_r[dcw_pkg::B_RAMP]);
   endproperty
   a_rfg: assert property (p_rfg) else $error("ramp generator reset wrong");

   property p_busin;
      @(posedge mclk_i) disable iff (!rst_n)
      ##1 bus_input_4_select_o == $past(ctw_r[15]);
   endproperty
   a_busin: assert property (p_busin) else $error("fieldbus input 4 mismatch");
endmodule : dcw_decoder

/* File: dcw_edge.sv */
// Rising edge detector, one per control bit
`timescale 1ns/10ps
module dcw_edge #(
   parameter int unsigned N = 2
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [N-1:0] d_i,
   output logic [N-1:0] rise_o
);
   logic [N-1:0] prev_r;
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_bit
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               prev_r[g] <= 1'b0;
            end else begin
               prev_r[g] <= d_i[g];
            end
         end
         assign rise_o[g] = d_i[g] & ~prev_r[g];
      end
   endgenerate
endmodule : dcw_edge

/* File: dcw_pkg.sv */
// Constants and types for the drive control word decoder
package dcw_pkg;
   localparam int unsigned CW_W = 16;
   localparam int unsigned AW = 8;
   // Control word bit positions
   localparam int unsigned B_ON = 0;
   localparam int unsigned B_COAST = 1;
   localparam int unsigned B_QSTOP = 2;
   localparam int unsigned B_OPER = 3;
   localparam int unsigned B_RAMP = 4;
   localparam int unsigned B_UNFRZ = 5;
   localparam int unsigned B_REFEN = 6;
   localparam int unsigned B_EVRST = 7;
   localparam int unsigned B_FBCTL = 10;
   localparam int unsigned B_IN_LO = 12;
   localparam int unsigned N_BUSIN = 4;
   localparam int unsigned N_EVT = 4;
   localparam int unsigned N_IRQ = 3;
   // Register byte offsets
   localparam logic [7:0] OFS_CTW = 8'h00;
   localparam logic [7:0] OFS_SPEED = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // Reset values
   localparam logic [15:0] CTW_RST = 16'h0000;
   localparam logic [15:0] SPEED_RST = 16'h0000;
   localparam logic CFG_PLACE_RST = 1'b1;
   localparam logic [2:0] MASK_RST = 3'h0;
   // Interrupt status bits
   localparam int unsigned IRQ_EVT = 0;
   localparam int unsigned IRQ_LOCK = 1;
   localparam int unsigned IRQ_RUN = 2;
   typedef enum logic [2:0] {
      S_LOCK = 3'h0,
      S_READY = 3'h1,
      S_ON = 3'h2,
      S_RUN = 3'h3,
      S_RAMP = 3'h4,
      S_QSTOP = 3'h5
   } dcw_state_e;
endpackage : dcw_pkg

/* File: dcw_plc_model.sv */
// Fieldbus controller model issuing classic Wishbone cycles
`timescale 1ns/10ps
module dcw_plc_model (
   input wire logic mclk_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i
);
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0000_0000;
   end

   // No answer time assumed; only the bench timeout ends a wait
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
      @(posedge mclk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'h3;
      wb_dat_o <= wdat;
      do @(posedge mclk_i); while (wb_ack_i !== 1'b1);
      rdat = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      // Released data lines flip so a stale word is never read as live
      wb_dat_o <= ~wdat;
   endtask : xfer
endmodule : dcw_plc_model

/* File: tb_dcw_decoder.sv */
// Self-checking bench for the control word decoder
`timescale 1ns/10ps
module tb_dcw_decoder;
   localparam int unsigned TMO = 20000;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat, rdat;
   logic [3:0] evt_cond = 4'h0;
   logic speed_zero = 1'b0;
   logic run, coast, qstop, rdown, rfg_rst, lockout, irq;
   logic [15:0] speed_ref;
   logic [3:0] bus_in, events;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc_cnt = 0;

   always #5 mclk_i = ~mclk_i;

   dcw_plc_model u_dcw_plc_model (
      .mclk_i(mclk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
      .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack)
   );

   dcw_decoder u_dcw_decoder (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .evt_cond_i(evt_cond), .speed_zero_i(speed_zero), .run_o(run), .coast_o(coast),
      .quick_stop_o(qstop), .ramp_down_o(rdown), .ramp_function_generator_reset_o(rfg_rst),
      .speed_ref_o(speed_ref), .bus_input_1_select_o(bus_in[0]), .bus_input_2_select_o(bus_in[1]),
      .bus_input_3_select_o(bus_in[2]), .bus_input_4_select_o(bus_in[3]), .lockout_o(lockout),
      .events_o(events), .irq_o(irq)
   );

   task automatic final_report;
      $display("mismatches %0d checks %0d", n_fail, samples_checked);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Outputs settle up to two edges after the ack edge (speed_ref_o, irq_o, events_o); three edges leave margin
   task automatic settle;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask : settle

   task automatic wr(input logic [7:0] adr, input logic [15:0] d);
      logic [31:0] dummy;
      u_dcw_plc_model.xfer(1'b1, adr, {16'h0000, d}, dummy);
      settle();
   endtask : wr

   task automatic rd(input logic [7:0] adr, output logic [31:0] d);
      u_dcw_plc_model.xfer(1'b0, adr, 32'h0000_0000, d);
   endtask : rd

   task automatic ctw(input logic [15:0] d);
      wr(dcw_pkg::OFS_CTW, d);
   endtask : ctw

   task automatic cond(input logic sz, input logic [3:0] ev);
      @(posedge mclk_i);
      speed_zero <= sz;
      evt_cond <= ev;
      settle();
   endtask : cond

   task automatic start;
      ctw(16'h0006);
      ctw(16'h0007);
      ctw(16'h000F);
   endtask : start

   always @(posedge mclk_i) begin
      cyc_cnt++;
      if (cyc_cnt == TMO) begin
         n_fail++;
         $display("MISMATCH t=%0t timeout", $time);
         final_report();
      end
   end

   initial begin
      repeat (7) @(posedge mclk_i);
      #1;
      chk({lockout, coast, rfg_rst, run, irq, wb_ack}, 6'h38, "reset levels");
      @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rd(dcw_pkg::OFS_CFG, rdat);
      chk(rdat[0], dcw_pkg::CFG_PLACE_RST, "cfg reset");
      rd(dcw_pkg::OFS_IRQ_MASK, rdat);
      chk(rdat[2:0], dcw_pkg::MASK_RST, "mask reset");
      rd(8'h3C, rdat);
      chk(rdat, 32'h0000_0000, "unmapped read");
      wr(dcw_pkg::OFS_STATE, 16'h0003);
      rd(dcw_pkg::OFS_STATE, rdat);
      chk(rdat[2:0], dcw_pkg::S_LOCK, "state read only");
      // Fieldbus not in command: word kept, sequencer deaf
      wr(dcw_pkg::OFS_CFG, 16'h0000);
      ctw(16'h1006);
      chk(lockout, 1'b1, "no control place");
      chk(bus_in, 4'h1, "bus input passes");
      rd(dcw_pkg::OFS_CTW, rdat);
      chk(rdat[15:0], 16'h1006, "ctw readback");
      wr(dcw_pkg::OFS_CFG, 16'h0001);
      chk(lockout, 1'b0, "lockout left");
      ctw(16'h000E);
      ctw(16'h000F);
      chk(run, 1'b0, "steady bit3 no start");
      ctw(16'h0007);
      ctw(16'h000F);
      chk({run, coast}, 2'h2, "rising bit3 start");
      ctw(16'h000E);
      chk({rdown, run}, 2'h3, "ramp to zero");
      cond(1'b1, 4'h0);
      chk({run, lockout}, 2'h0, "ramp done ready");
      cond(1'b0, 4'h0);
      ctw(16'h0007);
      ctw(16'h000F);
      ctw(16'h0007);
      chk({run, coast}, 2'h1, "bit3 low coasts");
      ctw(16'h000F);
      chk(run, 1'b1, "restart");
      ctw(16'h000D);
      chk({run, coast}, 2'h1, "bit1 low coasts");
      start();
      ctw(16'h000B);
      chk(qstop, 1'b1, "quick stop");
      cond(1'b1, 4'h0);
      chk({lockout, qstop}, 2'h2, "quick stop to lockout");
      cond(1'b0, 4'h0);
      ctw(16'h0007);
      chk(lockout, 1'b1, "lockout needs off");
      ctw(16'h0006);
      chk(lockout, 1'b0, "off clears lockout");
      start();
      wr(dcw_pkg::OFS_IRQ_STAT, 16'h0007);
      cond(1'b0, 4'h3);
      chk({lockout, run}, 2'h2, "fault to lockout");
      chk(events, 4'h3, "events set");
      cond(1'b0, 4'h1);
      rd(dcw_pkg::OFS_IRQ_STAT, rdat);
      chk(rdat[2:0], 3'h3, "irq status");
      chk(irq, 1'b0, "irq masked");
      wr(dcw_pkg::OFS_IRQ_MASK, 16'h0003);
      chk(irq, 1'b1, "irq unmasked");
      ctw(16'h0080);
      chk(events, 4'h1, "live event stays");
      cond(1'b0, 4'h0);
      ctw(16'h0000);
      ctw(16'h0080);
      chk(events, 4'h0, "events cleared");
      wr(dcw_pkg::OFS_IRQ_STAT, 16'h0003);
      chk(irq, 1'b0, "irq cleared");
      wr(dcw_pkg::OFS_IRQ_MASK, 16'h0000);
      ctw(16'h0010);
      chk(rfg_rst, 1'b0, "ramp enabled");
      ctw(16'h0000);
      chk(rfg_rst, 1'b1, "ramp reset");
      wr(dcw_pkg::OFS_SPEED, 16'h1234);
      ctw(16'h0460);
      chk(speed_ref, 16'h1234, "ref accepted");
      wr(dcw_pkg::OFS_SPEED, 16'h2345);
      chk(speed_ref, 16'h2345, "ref follows");
      ctw(16'h0440);
      wr(dcw_pkg::OFS_SPEED, 16'h0AAA);
      chk(speed_ref, 16'h2345, "ref frozen");
      ctw(16'h0420);
      chk(speed_ref, 16'h0000, "ref forced zero");
      ctw(16'h0060);
      wr(dcw_pkg::OFS_SPEED, 16'h0BBB);
      chk(speed_ref, 16'h0AAA, "new data ignored");
      for (int i = 0; i < 4; i++) begin
         ctw(16'h0B00 | (16'h1000 << i));
         chk(bus_in, 4'h1 << i, "bus input walk");
         chk({lockout, run}, 2'h2, "reserved bits ignored");
      end
      // Start sequence with reserved bits set must still run
      ctw(16'h0B06);
      ctw(16'h0B07);
      ctw(16'h0B0F);
      chk({run, coast}, 2'h2, "reserved bits ignored in run");
      final_report();
   end
endmodule : tb_dcw_decoder
